/* src/sram_host.sv */
// Purpose: host controller driving an asynchronous 1M x 32 SRAM module
// Assumes: one request at a time, inputs synchronous to CLK_SYS
// Notes: all pin outputs registered; output enable kept high on writes
//
// Behaviour
// - address moves only with strobe high
// - write only while select and write low
// - address held 3 ns after write end
// - select and address 17 ns before end
// - write data valid 12 ns before end
// - host never drives while module outputs
// - output enable high, 15 ns pulse suffices

`timescale 1ns/1ns
`default_nettype none

module sram_host #(
  parameter int ACC_CYCLES = sram_host_pkg::ACC_CYC,
  parameter int REL_CYCLES = sram_host_pkg::REL_CYC,
  parameter int PULSE_CYCLES = sram_host_pkg::PULSE_CYC,
  parameter int REC_CYCLES = sram_host_pkg::REC_CYC
) (
  input wire logic CLK_SYS, // system clock
  input wire logic RESET_N, // synchronous reset, active low
  input wire logic REQ_VALID, // request present
  output logic REQ_READY, // request taken when valid and ready
  input wire logic REQ_WRITE, // 1 write, 0 read
  input wire logic [19:0] REQ_ADDR, // word address
  input wire logic [31:0] REQ_WDATA, // write data
  input wire logic [3:0] REQ_BYTE_EN, // byte lanes to access
  output logic RSP_VALID, // read data pulse
  output logic [31:0] RSP_RDATA, // read data
  output logic DENSITY_OK, // module reports 1M depth
  output logic [3:0] DENSITY_SEEN, // last sampled density code
  output logic [19:0] WORD_ADDRESS, // module address pins
  output logic [3:0] BYTE_LANE_SELECT_N, // lane selects, active low
  output logic WRITE_ENABLE_N, // write strobe, active low
  output logic OUTPUT_ENABLE_N, // output enable, active low
  output logic [31:0] DATA_LINES_O, // data driven to module
  output logic DATA_LINES_OE, // high while host drives data
  input wire logic [31:0] DATA_LINES_I, // data from module
  input wire logic [3:0] DENSITY_CODE_PINS // density pins, open reads high
);

  // ==========================================================
  // state and phase timer
  sram_host_pkg::state_t state;
  sram_host_pkg::state_t next_state;
  logic timer_done;
  logic timer_load;
  logic [sram_host_pkg::TIMER_W-1:0] timer_val;
  logic [3:0] lane_en;

  wire take = REQ_VALID && REQ_READY;
  assign REQ_READY = (state == sram_host_pkg::ST_IDLE);

  function automatic logic [sram_host_pkg::TIMER_W-1:0] phase_len(
    input sram_host_pkg::state_t s
  );
    int n;
    case (s)
      sram_host_pkg::ST_RD_ACC: n = ACC_CYCLES;
      sram_host_pkg::ST_RD_REL: n = REL_CYCLES;
      // pulse covers select, address, data setup
      sram_host_pkg::ST_WR_PULSE: n = PULSE_CYCLES;
      sram_host_pkg::ST_WR_REC: n = REC_CYCLES;
      default: n = sram_host_pkg::SET_CYC;
    endcase
    return sram_host_pkg::TIMER_W'(n - 1);
  endfunction

  always_comb begin
    next_state = state;
    case (state)
      sram_host_pkg::ST_IDLE: begin
        if (take) begin
          next_state = REQ_WRITE ? sram_host_pkg::ST_WR_SET : sram_host_pkg::ST_RD_ACC;
        end
      end
      sram_host_pkg::ST_RD_ACC: begin
        if (timer_done) next_state = sram_host_pkg::ST_RD_REL;
      end
      sram_host_pkg::ST_RD_REL: begin
        if (timer_done) next_state = sram_host_pkg::ST_IDLE;
      end
      sram_host_pkg::ST_WR_SET: begin
        if (timer_done) next_state = sram_host_pkg::ST_WR_PULSE;
      end
      sram_host_pkg::ST_WR_PULSE: begin
        if (timer_done) next_state = sram_host_pkg::ST_WR_REC;
      end
      sram_host_pkg::ST_WR_REC: begin
        if (timer_done) next_state = sram_host_pkg::ST_IDLE;
      end
      default: next_state = sram_host_pkg::ST_IDLE;
    endcase
  end

  assign timer_load = (next_state != state);
  assign timer_val = phase_len(next_state);

  phase_timer #(
    .W(sram_host_pkg::TIMER_W)
  ) u_timer (
    .CLK_SYS(CLK_SYS),
    .RESET_N(RESET_N),
    .load(timer_load),
    .load_val(timer_val),
    .done(timer_done)
  );

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      state <= sram_host_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // strobe decode from the coming state
  // overlap only in pulse
  wire next_wr_pulse = (next_state == sram_host_pkg::ST_WR_PULSE);
  wire next_rd_acc = (next_state == sram_host_pkg::ST_RD_ACC);
  // output enable held high on writes, so plain pulse width is enough
  wire next_oe_n = !next_rd_acc;
  wire next_we_n = !next_wr_pulse;
  // select and write fall on one edge, module keeps floating
  wire lanes_active = next_wr_pulse || next_rd_acc;
  // drive data only from write setup through recovery
  wire next_dq_oe = (next_state == sram_host_pkg::ST_WR_SET) || next_wr_pulse ||
                    (next_state == sram_host_pkg::ST_WR_REC);
  // address only loads from idle, with write strobe high
  // address and data held through recovery
  wire addr_load = take;

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      lane_en <= 4'h0;
    end else if (take) begin
      lane_en <= REQ_BYTE_EN;
    end
  end

  genvar g;
  generate
    for (g = 0; g < sram_host_pkg::LANES; g++) begin : g_lane
      // select g owns data byte g
      always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
          BYTE_LANE_SELECT_N[g] <= 1'b1;
        end else begin
          BYTE_LANE_SELECT_N[g] <= !(lanes_active &&
                                     (take ? REQ_BYTE_EN[g] : lane_en[g]));
        end
      end
    end
  endgenerate

  // ==========================================================
  // pin registers
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      WORD_ADDRESS <= 20'h00000;
      DATA_LINES_O <= 32'h00000000;
    end else if (addr_load) begin
      WORD_ADDRESS <= REQ_ADDR;
      DATA_LINES_O <= REQ_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      WRITE_ENABLE_N <= 1'b1;
      OUTPUT_ENABLE_N <= 1'b1;
      DATA_LINES_OE <= 1'b0;
    end else begin
      WRITE_ENABLE_N <= next_we_n;
      OUTPUT_ENABLE_N <= next_oe_n;
      DATA_LINES_OE <= next_dq_oe;
    end
  end

  // ==========================================================
  // read capture and density check
  // sample after the full access time
  wire rd_sample = (state == sram_host_pkg::ST_RD_ACC) && timer_done;

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 32'h00000000;
    end else begin
      RSP_VALID <= rd_sample;
      if (rd_sample) RSP_RDATA <= DATA_LINES_I;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      DENSITY_SEEN <= 4'h0;
      DENSITY_OK <= 1'b0;
    end else begin
      DENSITY_SEEN <= DENSITY_CODE_PINS;
      DENSITY_OK <= (DENSITY_CODE_PINS == sram_host_pkg::DENSITY_1M);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  a_addr_move_safe: assert property (
    !$stable(WORD_ADDRESS) |-> WRITE_ENABLE_N
  ) else $error("address moved with write strobe low");

  a_write_overlap: assert property (
    (!WRITE_ENABLE_N && !(&BYTE_LANE_SELECT_N)) |->
      ($past(state) != sram_host_pkg::ST_IDLE) && DATA_LINES_OE
  ) else $error("write overlap outside a write");

  a_recovery_hold: assert property (
    $rose(WRITE_ENABLE_N) |-> $stable(WORD_ADDRESS) && DATA_LINES_OE
  ) else $error("address or data moved at write end");

  a_select_before_end: assert property (
    $fell(WRITE_ENABLE_N) |->
      (!WRITE_ENABLE_N && !(&BYTE_LANE_SELECT_N)) ##1
      (!WRITE_ENABLE_N && $stable(BYTE_LANE_SELECT_N)) ##1
      (WRITE_ENABLE_N && (&BYTE_LANE_SELECT_N))
  ) else $error("write pulse length wrong");

  a_data_before_end: assert property (
    $fell(WRITE_ENABLE_N) |-> (DATA_LINES_OE && $stable(DATA_LINES_O))[*2]
  ) else $error("write data not held through pulse");

  a_no_drive_read: assert property (
    DATA_LINES_OE |-> OUTPUT_ENABLE_N && ($past(OUTPUT_ENABLE_N))
  ) else $error("host drives while module may output");

  a_pulse_oe_high: assert property (
    !WRITE_ENABLE_N |-> OUTPUT_ENABLE_N
  ) else $error("output enable low during write pulse");

  a_read_sample: assert property (
    $fell(OUTPUT_ENABLE_N) |-> !RSP_VALID ##1 !RSP_VALID ##1 RSP_VALID
  ) else $error("read sampled at wrong time");

endmodule

`default_nettype wire

/* src/sram_host_pkg.sv */
// Purpose: shared constants for the asynchronous SRAM module host
// Assumes: 100 MHz system clock, fastest speed grade timing
// Notes: cycle counts round least times up to whole cycles

package sram_host_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DENS_W = 4;
  // pins 0..3: ground, open, ground, open; open reads high via pull-up
  localparam logic [3:0] DENSITY_1M = 4'hA;

  // ==========================================================
  // timing in ns, fastest grade
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_AA_NS = 20;
  localparam int T_ACS_NS = 20;
  localparam int T_OE_NS = 12;
  localparam int T_CHZ_NS = 10;
  localparam int T_OHZ_NS = 10;
  localparam int T_CW_NS = 17;
  localparam int T_AW_NS = 17;
  localparam int T_WP_NS = 15;
  localparam int T_DW_NS = 12;
  localparam int T_WR_NS = 3;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // ==========================================================
  // cycle counts
  localparam int ACC_CYC = ns_to_cyc(max2(max2(T_AA_NS, T_ACS_NS), T_OE_NS));
  localparam int REL_CYC = ns_to_cyc(max2(T_CHZ_NS, T_OHZ_NS));
  localparam int PULSE_CYC =
    ns_to_cyc(max2(max2(T_CW_NS, T_AW_NS), max2(T_WP_NS, T_DW_NS)));
  localparam int REC_CYC = ns_to_cyc(T_WR_NS);
  localparam int SET_CYC = 1;
  localparam int TIMER_W = 4;

  // ==========================================================
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD_ACC = 6'h02,
    ST_RD_REL = 6'h04,
    ST_WR_SET = 6'h08,
    ST_WR_PULSE = 6'h10,
    ST_WR_REC = 6'h20
  } state_t;

endpackage

/* src/phase_timer.sv */
// Purpose: down counter timing each strobe phase
// Assumes: load value is the phase length minus one
// Notes: done is combinational so the sequencer leaves on time

`timescale 1ns/1ns
`default_nettype none

module phase_timer #(
  parameter int W = 4
) (
  input wire logic CLK_SYS, // system clock
  input wire logic RESET_N, // synchronous reset, active low
  input wire logic load, // start a new phase
  input wire logic [W-1:0] load_val, // phase length minus one
  output logic done // last cycle of phase
);

  logic [W-1:0] count;

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0);

endmodule

`default_nettype wire

/* testbench/sram_module_model.sv */
// Purpose: behavioural 1M x 32 asynchronous SRAM module
// Assumes: host changes strobes only just after clock edges
// Notes: a lane that is not driving shows the inverse of its word

`timescale 1ns/1ns
`default_nettype none

module sram_module_model #(
  parameter int ACC_NS = 15
) (
  input wire logic [19:0] word_address, // address pins
  input wire logic [3:0] byte_lane_select_n, // lane selects, active low
  input wire logic write_enable_n, // write strobe, active low
  input wire logic output_enable_n, // output enable, active low
  input wire logic [31:0] data_in, // data lines as the host leaves them
  output logic [31:0] data_out, // data lines as the module leaves them
  output logic [3:0] lane_drive, // lane drives its data lines
  output logic [3:0] density_code_pins // density id, open pins pulled high
);
  logic [31:0] mem [0:1048575];
  logic [3:0] wr_act;

  assign density_code_pins = 4'hA;

  for (genvar g = 0; g < 4; g++) begin : lane
    assign lane_drive[g] = !byte_lane_select_n[g] && !output_enable_n && write_enable_n;
    // byte g on lines 8g up
    assign #(ACC_NS) data_out[8*g +: 8] =
      lane_drive[g] ? mem[word_address][8*g +: 8] : ~mem[word_address][8*g +: 8];
    // lane stores at end of write
    assign wr_act[g] = !byte_lane_select_n[g] && !write_enable_n;
    always @(negedge wr_act[g]) begin
      mem[word_address][8*g +: 8] = data_in[8*g +: 8];
    end
  end
endmodule

`default_nettype wire

/* testbench/tb_sram_host.sv */
// Purpose: self-checking bench for the SRAM module host
// Assumes: behavioural module model on the far side
// Notes: only enabled bytes of read data are compared

`timescale 1ns/1ns
`default_nettype none

module tb_sram_host;
  logic CLK_SYS = 1'b0;
  logic RESET_N = 1'b0;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [19:0] REQ_ADDR = 20'h00000;
  logic [31:0] REQ_WDATA = 32'h00000000;
  logic [3:0] REQ_BYTE_EN = 4'hF;
  logic [3:0] dens_flip = 4'h0;
  logic REQ_READY, RSP_VALID, DENSITY_OK, WRITE_ENABLE_N, OUTPUT_ENABLE_N, DATA_LINES_OE;
  logic [31:0] RSP_RDATA, DATA_LINES_O, DATA_LINES_I, bus_in;
  logic [3:0] DENSITY_SEEN, BYTE_LANE_SELECT_N, lane_drive, dens;
  logic [19:0] WORD_ADDRESS, prev_addr;
  logic [31:0] shadow [bit [19:0]];
  logic [19:0] pool [8];
  logic prev_act = 1'b0;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int wl = 0;
  int seed = 32'h4a819f86;

  always #5 CLK_SYS = ~CLK_SYS;
  // undriven host lines read back as the inverse of DATA_LINES_O
  assign bus_in = DATA_LINES_OE ? DATA_LINES_O : ~DATA_LINES_O;

  sram_host DUT (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_BYTE_EN(REQ_BYTE_EN), .RSP_VALID(RSP_VALID),
    .RSP_RDATA(RSP_RDATA), .DENSITY_OK(DENSITY_OK), .DENSITY_SEEN(DENSITY_SEEN),
    .WORD_ADDRESS(WORD_ADDRESS), .BYTE_LANE_SELECT_N(BYTE_LANE_SELECT_N),
    .WRITE_ENABLE_N(WRITE_ENABLE_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
    .DATA_LINES_O(DATA_LINES_O), .DATA_LINES_OE(DATA_LINES_OE),
    .DATA_LINES_I(DATA_LINES_I), .DENSITY_CODE_PINS(dens ^ dens_flip));

  sram_module_model model (.word_address(WORD_ADDRESS), .byte_lane_select_n(BYTE_LANE_SELECT_N),
    .write_enable_n(WRITE_ENABLE_N), .output_enable_n(OUTPUT_ENABLE_N), .data_in(bus_in),
    .data_out(DATA_LINES_I), .lane_drive(lane_drive), .density_code_pins(dens));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one request, then the read result two edges after the take
  task automatic op(input logic w, input logic [19:0] a, input logic [31:0] d,
      input logic [3:0] be);
    logic [31:0] m;
    int n;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    n = 0;
    while (REQ_READY !== 1'b1 && n < 20) begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    REQ_VALID = 1'b1;
    REQ_WRITE = w;
    REQ_ADDR = a;
    REQ_WDATA = d;
    REQ_BYTE_EN = be;
    @(posedge CLK_SYS);
    #1;
    REQ_VALID = 1'b0;
    check("ready_busy", {31'h0, REQ_READY}, 32'h0);
    REQ_WDATA = $random(seed);
    if (w) begin
      shadow[a] = (shadow[a] & ~m) | (d & m);
    end else begin
      repeat (2) @(posedge CLK_SYS);
      #1;
      check("rsp_valid", {31'h0, RSP_VALID}, 32'h1);
      check("rd_data", RSP_RDATA & m, shadow[a] & m);
    end
  endtask

  // bus watch between edges, where outputs have settled
  always @(negedge CLK_SYS) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
    check("bus_conflict", {31'h0, DATA_LINES_OE && |lane_drive}, 32'h0);
    if (!WRITE_ENABLE_N) check("oe_in_write", {31'h0, OUTPUT_ENABLE_N}, 32'h1);
    if (prev_act && !WRITE_ENABLE_N && WORD_ADDRESS !== prev_addr) check("addr_move", 1, 0);
    if (!WRITE_ENABLE_N) begin
      wl++;
    end else if (wl != 0) begin
      check("write_pulse", wl, sram_host_pkg::PULSE_CYC);
      wl = 0;
    end
    prev_act = !WRITE_ENABLE_N && BYTE_LANE_SELECT_N != 4'hF;
    prev_addr = WORD_ADDRESS;
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      pool[i] = (i == 0) ? 20'h00000 : (i == 7) ? 20'hFFFFF : 20'($random(seed));
    end
    repeat (3) @(posedge CLK_SYS);
    #1;
    check("rst_sel", {28'h0, BYTE_LANE_SELECT_N}, 32'hF);
    check("rst_strobes", {29'h0, WRITE_ENABLE_N, OUTPUT_ENABLE_N, DATA_LINES_OE}, 32'h6);
    RESET_N = 1'b1;
    repeat (3) @(posedge CLK_SYS);
    #1;
    check("density_ok", {31'h0, DENSITY_OK}, 32'h1);
    check("density_seen", {28'h0, DENSITY_SEEN}, 32'hA);
    dens_flip = 4'h1;
    repeat (3) @(posedge CLK_SYS);
    #1;
    check("density_bad", {31'h0, DENSITY_OK}, 32'h0);
    dens_flip = 4'h0;
    $display("test density done");
    for (int i = 0; i < 8; i++) begin
      op(1'b1, pool[i], $random(seed), 4'hF);
    end
    $display("test fill done");
    for (int i = 0; i < 200; i++) begin
      op(1'($random(seed)), pool[$unsigned($random(seed)) % 8], $random(seed),
        4'((i % 15) + 1));
    end
    $display("test mixed done");
    end_of_test();
  end
endmodule

`default_nettype wire
